// >>> batmon_i2c_pkg.sv
package batmon_i2c_pkg;

    localparam logic [6:0] TARGET_ADDR   = 7'h64;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_TX_BIT   = 4'h7;
    localparam int         IRQ_BITS      = 4;

    // Sub-address of each of the eight registers.
    localparam logic [7:0] SUB_A = 8'h00;
    localparam logic [7:0] SUB_B = 8'h01;
    localparam logic [7:0] SUB_C = 8'h02;
    localparam logic [7:0] SUB_D = 8'h03;
    localparam logic [7:0] SUB_E = 8'h04;
    localparam logic [7:0] SUB_F = 8'h05;
    localparam logic [7:0] SUB_G = 8'h06;
    localparam logic [7:0] SUB_H = 8'h07;

    // Slots of the writable registers; SLOT_NONE marks any other pointer value.
    localparam logic [1:0] SLOT_A    = 2'h0;
    localparam logic [1:0] SLOT_B    = 2'h1;
    localparam logic [1:0] SLOT_H    = 2'h2;
    localparam logic [1:0] SLOT_NONE = 2'h3;

    localparam logic [15:0] CMD_RESET = 16'h0000;

    localparam int LINK_CLK_KHZ = 8000;
    localparam int GLITCH_NS    = 250;
    localparam int GLITCH_CYC   = ((GLITCH_NS * LINK_CLK_KHZ) + 999999) / 1000000 < 1 ? 1 :
                                  ((GLITCH_NS * LINK_CLK_KHZ) + 999999) / 1000000;

    typedef logic [15:0] word_t;

    typedef struct packed {
        word_t c;
        word_t d;
        word_t e;
        word_t f;
        word_t g;
    } status_t;

    typedef struct packed {
        word_t a;
        word_t b;
        word_t h;
    } cmd_t;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_SUB, ST_SUB_ACK, ST_DLO, ST_DLO_ACK,
        ST_DHI, ST_DHI_ACK, ST_RD, ST_RD_ACK, ST_RD_DONE
    } link_st_t;

    typedef struct packed {
        link_st_t    st;
        logic        scl_q;
        logic        sda_q;
        logic [3:0]  cnt;
        logic [7:0]  sh;
        logic        rd;
        logic        hi;
        logic [7:0]  ptr;
        logic [7:0]  lo;
        cmd_t        pend;
        logic [2:0]  mod;
        cmd_t        cmd;
        logic        oe;
        logic        lvl;
        logic        req_t;
        logic        ack_q;
        logic [7:0]  req_ptr;
        word_t       tx;
        logic        stop_t;
    } link_state_t;

    typedef struct packed {
        status_t     shadow;
        logic        lat;
        logic [3:0]  lat_c;
        logic        irq_n;
        word_t       xfer;
        logic        ack_t;
        logic        stop_q;
        cmd_t        cmd;
        logic        upd;
    } core_state_t;

    localparam link_state_t LINK_RST = '{st: ST_IDLE, scl_q: 1'b1, sda_q: 1'b1, default: '0};
    localparam core_state_t CORE_RST = '{irq_n: 1'b1, default: '0};

    function automatic logic [1:0] cmd_slot(input logic [7:0] ptr);
        case (ptr)
            SUB_A:   cmd_slot = SLOT_A;
            SUB_B:   cmd_slot = SLOT_B;
            SUB_H:   cmd_slot = SLOT_H;
            default: cmd_slot = SLOT_NONE;
        endcase
    endfunction : cmd_slot

    function automatic word_t get_word(input cmd_t c, input logic [1:0] slot);
        case (slot)
            SLOT_A:  get_word = c.a;
            SLOT_B:  get_word = c.b;
            SLOT_H:  get_word = c.h;
            default: get_word = CMD_RESET;
        endcase
    endfunction : get_word

endpackage : batmon_i2c_pkg

// >>> line_filter.sv
`timescale 1ns/100ps
module line_filter #(
    parameter int   LEN      = 2,
    parameter logic IDLE_LVL = 1'b1
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic d,
    output logic      q
);
    localparam int CW = $clog2(LEN + 1);

    typedef struct packed {
        logic          s1;
        logic          s2;
        logic [CW-1:0] cnt;
        logic          q;
    } filt_t;

    localparam filt_t FILT_RST = '{s1: IDLE_LVL, s2: IDLE_LVL, cnt: '0, q: IDLE_LVL};

    filt_t r;
    filt_t r_nxt;

    // The output follows only after the synchronised level differed for LEN cycles.
    always_comb
    begin
        r_nxt    = r;
        r_nxt.s1 = d;
        r_nxt.s2 = r.s1;
        if (r.s2 == r.q)
            r_nxt.cnt = '0;
        else if (r.cnt == CW'(LEN - 1))
        begin
            r_nxt.q   = r.s2;
            r_nxt.cnt = '0;
        end
        else
            r_nxt.cnt = r.cnt + 1'b1;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            r <= FILT_RST;
        else
            r <= r_nxt;
    end

    assign q = r.q;
endmodule : line_filter

// >>> bit_sync.sv
`timescale 1ns/100ps
module bit_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_t;

    sync_t r;
    sync_t r_nxt;

    always_comb
    begin
        r_nxt.s1 = d;
        r_nxt.s2 = r.s1;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            r <= '0;
        else
            r <= r_nxt;
    end

    assign q = r.s2;
endmodule : bit_sync

// >>> i2c_subaddr_register_port.sv
`timescale 1ns/100ps
module i2c_subaddr_register_port #(
    parameter int FILT_LEN = batmon_i2c_pkg::GLITCH_CYC
) (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic                    link_clk,
    input  wire logic                    scl_i,
    input  wire logic                    sda_i,
    output logic                         sda_o,
    output logic                         sda_oe,
    input  wire batmon_i2c_pkg::status_t status,
    input  wire logic                    conv_busy,
    input  wire logic                    alarm,
    input  wire logic                    irq_clear,
    output logic                         irq_n,
    output batmon_i2c_pkg::cmd_t         cmd,
    output logic                         cmd_update
);
    import batmon_i2c_pkg::*;

    link_state_t lr;
    link_state_t lr_nxt;
    core_state_t cr;
    core_state_t cr_nxt;

    logic        scl_f;
    logic        sda_f;
    logic        ack_s;
    logic [1:0]  core_s;
    logic        rise;
    logic        fall;
    logic        start;
    logic        stop;
    logic        got_byte;
    logic        rx_state;
    logic [1:0]  wr_slot;
    word_t       wr_word;

    // SCL is only ever sampled; no path drives it low.
    line_filter #(
        .LEN      (FILT_LEN),
        .IDLE_LVL (1'b1)
    ) u_scl_filt (
        .clk (link_clk),
        .rst (rst),
        .d   (scl_i),
        .q   (scl_f)
    );

    line_filter #(
        .LEN      (FILT_LEN),
        .IDLE_LVL (1'b1)
    ) u_sda_filt (
        .clk (link_clk),
        .rst (rst),
        .d   (sda_i),
        .q   (sda_f)
    );

    bit_sync #(
        .W (1)
    ) u_ack_sync (
        .clk (link_clk),
        .rst (rst),
        .d   (cr.ack_t),
        .q   (ack_s)
    );

    bit_sync #(
        .W (2)
    ) u_core_sync (
        .clk (clk),
        .rst (rst),
        .d   ({lr.req_t, lr.stop_t}),
        .q   (core_s)
    );

    assign rise     = scl_f & ~lr.scl_q;
    assign fall     = ~scl_f & lr.scl_q;
    assign start    = scl_f & lr.scl_q & lr.sda_q & ~sda_f;
    assign stop     = scl_f & lr.scl_q & ~lr.sda_q & sda_f;
    assign got_byte = fall & (lr.cnt == BITS_PER_BYTE);
    assign rx_state = (lr.st == ST_ADDR) | (lr.st == ST_SUB) | (lr.st == ST_DLO) | (lr.st == ST_DHI);
    assign wr_slot  = cmd_slot(lr.ptr);
    assign wr_word  = {lr.sh, lr.lo};

    // Link side: bit engine, pointer, pending and command words.
    always_comb
    begin
        lr_nxt       = lr;
        lr_nxt.scl_q = scl_f;
        lr_nxt.sda_q = sda_f;
        lr_nxt.lvl   = 1'b0;
        // The status word is only taken once the core has answered the request.
        if (ack_s != lr.ack_q)
        begin
            lr_nxt.ack_q = ack_s;
            lr_nxt.tx    = cr.xfer;
        end
        if (rx_state && rise && (lr.cnt != BITS_PER_BYTE))
        begin
            lr_nxt.sh  = {lr.sh[6:0], sda_f};
            lr_nxt.cnt = lr.cnt + 4'h1;
        end
        if (start)
        begin
            lr_nxt.st  = ST_ADDR;
            lr_nxt.cnt = 4'h0;
            lr_nxt.oe  = 1'b0;
        end
        else if (stop)
        begin
            lr_nxt.st     = ST_IDLE;
            lr_nxt.oe     = 1'b0;
            lr_nxt.cmd    = lr.pend;
            lr_nxt.mod    = 3'h0;
            lr_nxt.stop_t = ~lr.stop_t;
        end
        else
        begin
            case (lr.st)
                ST_IDLE, ST_RD_DONE:
                    lr_nxt.oe = 1'b0;
                ST_ADDR:
                    if (got_byte)
                    begin
                        lr_nxt.cnt = 4'h0;
                        if (lr.sh[7:1] == TARGET_ADDR)
                        begin
                            lr_nxt.oe = 1'b1;
                            lr_nxt.st = ST_ADDR_ACK;
                            lr_nxt.rd = lr.sh[0];
                            if (lr.sh[0])
                            begin
                                // Only the pointed register is prepared.
                                case (cmd_slot(lr.ptr))
                                    SLOT_A, SLOT_H:
                                        lr_nxt.tx = lr.mod[cmd_slot(lr.ptr)] ? get_word(lr.pend, cmd_slot(lr.ptr))
                                                                             : get_word(lr.cmd, cmd_slot(lr.ptr));
                                    SLOT_B:
                                        lr_nxt.tx = lr.cmd.b;
                                    default:
                                        if ((lr.ptr >= SUB_C) && (lr.ptr <= SUB_G))
                                        begin
                                            lr_nxt.req_ptr = lr.ptr;
                                            lr_nxt.req_t   = ~lr.req_t;
                                        end
                                        else
                                            lr_nxt.tx = CMD_RESET;
                                endcase
                            end
                        end
                        else
                            lr_nxt.st = ST_IDLE;
                    end
                ST_ADDR_ACK:
                    if (fall)
                    begin
                        lr_nxt.cnt = 4'h0;
                        if (lr.rd)
                        begin
                            lr_nxt.st = ST_RD;
                            lr_nxt.hi = 1'b0;
                            lr_nxt.sh = lr.tx[7:0];
                            lr_nxt.oe = ~lr.tx[7];
                        end
                        else
                        begin
                            lr_nxt.st = ST_SUB;
                            lr_nxt.oe = 1'b0;
                        end
                    end
                ST_SUB:
                    if (got_byte)
                    begin
                        lr_nxt.ptr = lr.sh;
                        lr_nxt.oe  = 1'b1;
                        lr_nxt.cnt = 4'h0;
                        lr_nxt.st  = ST_SUB_ACK;
                    end
                ST_DLO:
                    if (got_byte)
                    begin
                        lr_nxt.lo  = lr.sh;
                        lr_nxt.oe  = 1'b1;
                        lr_nxt.cnt = 4'h0;
                        lr_nxt.st  = ST_DLO_ACK;
                    end
                ST_DHI:
                    if (got_byte)
                    begin
                        lr_nxt.oe  = 1'b1;
                        lr_nxt.cnt = 4'h0;
                        lr_nxt.st  = ST_DHI_ACK;
                    end
                ST_SUB_ACK:
                    if (fall)
                    begin
                        lr_nxt.oe = 1'b0;
                        lr_nxt.st = ST_DLO;
                    end
                ST_DLO_ACK:
                    if (fall)
                    begin
                        lr_nxt.oe = 1'b0;
                        lr_nxt.st = ST_DHI;
                    end
                ST_DHI_ACK:
                    // Storing only at the end of the second acknowledge keeps a cut write harmless.
                    if (fall)
                    begin
                        lr_nxt.oe = 1'b0;
                        lr_nxt.st = ST_SUB;
                        case (wr_slot)
                            SLOT_A:  lr_nxt.pend.a = wr_word;
                            SLOT_B:  lr_nxt.pend.b = wr_word;
                            SLOT_H:  lr_nxt.pend.h = wr_word;
                            default: lr_nxt.pend = lr.pend;
                        endcase
                        if (wr_slot != SLOT_NONE)
                            lr_nxt.mod[wr_slot] = 1'b1;
                    end
                ST_RD:
                    if (fall)
                    begin
                        if (lr.cnt == LAST_TX_BIT)
                        begin
                            lr_nxt.oe = 1'b0;
                            lr_nxt.st = ST_RD_ACK;
                        end
                        else
                        begin
                            lr_nxt.sh  = {lr.sh[6:0], 1'b0};
                            lr_nxt.oe  = ~lr.sh[6];
                            lr_nxt.cnt = lr.cnt + 4'h1;
                        end
                    end
                ST_RD_ACK:
                    // The master's answer on SDA is never looked at.
                    if (fall)
                    begin
                        lr_nxt.cnt = 4'h0;
                        if (!lr.hi)
                        begin
                            lr_nxt.hi = 1'b1;
                            lr_nxt.sh = lr.tx[15:8];
                            lr_nxt.oe = ~lr.tx[15];
                            lr_nxt.st = ST_RD;
                        end
                        else
                        begin
                            lr_nxt.oe = 1'b0;
                            lr_nxt.st = ST_RD_DONE;
                        end
                    end
                default:
                begin
                    lr_nxt.st = ST_IDLE;
                    lr_nxt.oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge link_clk or posedge rst)
    begin
        if (rst)
            lr <= LINK_RST;
        else
            lr <= lr_nxt;
    end

    // Core side: status shadow, alarm latch, snapshot answer and command update.
    always_comb
    begin
        cr_nxt     = cr;
        cr_nxt.upd = 1'b0;
        if (!conv_busy)
            cr_nxt.shadow = status;
        if (irq_clear)
        begin
            cr_nxt.lat   = 1'b0;
            cr_nxt.irq_n = 1'b1;
        end
        // A new alarm in the clearing cycle wins, so no event is lost.
        if (alarm)
        begin
            if (!cr.lat || irq_clear)
                cr_nxt.lat_c = status.c[IRQ_BITS-1:0];
            cr_nxt.lat   = 1'b1;
            cr_nxt.irq_n = 1'b0;
        end
        // The pointer was placed in the same link cycle as the request toggle and holds until answered.
        if (core_s[1] != cr.ack_t)
        begin
            cr_nxt.ack_t = core_s[1];
            case (lr.req_ptr)
                SUB_C:   cr_nxt.xfer = {cr_nxt.shadow.c[15:IRQ_BITS],
                                        cr.lat ? cr.lat_c : cr_nxt.shadow.c[IRQ_BITS-1:0]};
                SUB_D:   cr_nxt.xfer = cr_nxt.shadow.d;
                SUB_E:   cr_nxt.xfer = cr_nxt.shadow.e;
                SUB_F:   cr_nxt.xfer = cr_nxt.shadow.f;
                SUB_G:   cr_nxt.xfer = cr_nxt.shadow.g;
                default: cr_nxt.xfer = CMD_RESET;
            endcase
        end
        // Command words stay still between STOPs, far longer than the crossing takes.
        if (core_s[0] != cr.stop_q)
        begin
            cr_nxt.stop_q = core_s[0];
            cr_nxt.cmd    = lr.cmd;
            cr_nxt.upd    = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cr <= CORE_RST;
        else
            cr <= cr_nxt;
    end

    assign sda_o      = lr.lvl;
    assign sda_oe     = lr.oe;
    assign irq_n      = cr.irq_n;
    assign cmd        = cr.cmd;
    assign cmd_update = cr.upd;

    a_addr_ack: assert property (
        @(posedge link_clk) disable iff (rst)
        (lr.st == ST_ADDR && got_byte && !start && !stop && lr.sh[7:1] == TARGET_ADDR)
        |=> (lr.st == ST_ADDR_ACK && sda_oe) ##1 (sda_oe throughout (lr.st == ST_ADDR_ACK)[*1]))
        else $error("own address not acknowledged");

    a_ptr_load: assert property (
        @(posedge link_clk) disable iff (rst)
        (lr.st == ST_SUB && got_byte && !start && !stop) |=> (lr.ptr == $past(lr.sh) && sda_oe))
        else $error("pointer not loaded at sub-address acknowledge");

    a_pend_store: assert property (
        @(posedge link_clk) disable iff (rst)
        (lr.st == ST_DHI_ACK && fall && !start && !stop && wr_slot != SLOT_NONE)
        |=> (get_word(lr.pend, $past(wr_slot)) == $past(wr_word) && lr.st == ST_SUB))
        else $error("pending word not stored after two bytes");

    a_stop_copy: assert property (
        @(posedge link_clk) disable iff (rst)
        stop |=> (lr.cmd == $past(lr.pend) && lr.mod == 3'h0 && lr.stop_t != $past(lr.stop_t)))
        else $error("pending words not copied on stop");

    a_cmd_hold: assert property (
        @(posedge link_clk) disable iff (rst)
        !stop |=> $stable(lr.cmd))
        else $error("command words changed without stop");

    a_read_release: assert property (
        @(posedge link_clk) disable iff (rst)
        (lr.st == ST_RD_ACK && fall && lr.hi && !start && !stop) |=> (lr.st == ST_RD_DONE && !sda_oe))
        else $error("bus not released after second read byte");

    a_done_quiet: assert property (
        @(posedge link_clk) disable iff (rst)
        (lr.st == ST_RD_DONE) ##1 (lr.st == ST_RD_DONE) |-> !sda_oe && !$past(sda_oe))
        else $error("data line driven after read finished");

    a_read_noack: assert property (
        @(posedge link_clk) disable iff (rst)
        (lr.st == ST_RD && fall && lr.cnt == LAST_TX_BIT && !start && !stop) |=> !sda_oe [*2])
        else $error("read byte acknowledged by device");

    a_irq_set: assert property (
        @(posedge clk) disable iff (rst)
        alarm |=> (!irq_n && cr.lat) ##1 (!irq_n || $past(irq_clear)))
        else $error("alarm did not assert interrupt");

    a_busy_hold: assert property (
        @(posedge clk) disable iff (rst)
        conv_busy |=> (cr.shadow == $past(cr.shadow)))
        else $error("status shadow moved during conversion");

    a_cmd_update: assert property (
        @(posedge clk) disable iff (rst)
        (core_s[0] != cr.stop_q) |=> (cmd_update && cmd == $past(lr.cmd)) ##1 !cmd_update)
        else $error("command update pulse wrong");
endmodule : i2c_subaddr_register_port

// >>> i2c_master_model.sv
`timescale 1ns/100ps
module i2c_master_model #(
    parameter int Q = 625
) (
    output logic      scl,
    output logic      sda_rel,
    input  wire logic sda
);
    // The master owns the clock; it idles high and only moves inside frames.
    initial
    begin
        scl     = 1'b1;
        sda_rel = 1'b1;
    end
    task automatic bit_io(input logic b, output logic s);
        sda_rel = b;
        #Q scl = 1'b1;
        #Q s = sda;
        #Q scl = 1'b0;
        #Q;
    endtask : bit_io
    task automatic start();
        sda_rel = 1'b1;
        #Q scl = 1'b1;
        #Q sda_rel = 1'b0;
        #Q scl = 1'b0;
    endtask : start
    // A short SCL pulse while the clock is low; the input filter must swallow it.
    task automatic glitch();
        scl = 1'b1;
        #100 scl = 1'b0;
        #Q;
    endtask : glitch
    // Ends on the SDA rise so the caller can catch the command update pulse.
    task automatic stop();
        sda_rel = 1'b0;
        #Q scl = 1'b1;
        #Q sda_rel = 1'b1;
    endtask : stop
    task automatic send(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask : send
    task automatic recv(input logic mack, output logic [7:0] d, output logic rel);
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(~mack, rel);
    endtask : recv
endmodule : i2c_master_model

// >>> i2c_subaddr_register_port_test.sv
`timescale 1ns/100ps
module i2c_subaddr_register_port_test;
    import batmon_i2c_pkg::*;
    logic    clk = 1'b0;
    logic    link_clk = 1'b0;
    logic    rst = 1'b1;
    status_t status = '0;
    logic    conv_busy = 1'b0;
    logic    alarm = 1'b0;
    logic    irq_clear = 1'b0;
    logic    scl;
    logic    sda_rel;
    logic    sda_o;
    logic    sda_oe;
    logic    irq_n;
    logic    cmd_update;
    cmd_t    cmd;
    int      error_cnt = 0;
    int      comparisons = 0;
    int      cyc = 0;
    wire     sda = sda_rel & ~(sda_oe & ~sda_o);
    always #10 clk = ~clk;
    always #62.5 link_clk = ~link_clk;
    i2c_subaddr_register_port DUT (.clk(clk), .rst(rst), .link_clk(link_clk), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .status(status), .conv_busy(conv_busy), .alarm(alarm),
        .irq_clear(irq_clear), .irq_n(irq_n), .cmd(cmd), .cmd_update(cmd_update));
    i2c_master_model m (.scl(scl), .sda_rel(sda_rel), .sda(sda));
    task automatic chk(input string name, input logic [47:0] seen, input logic [47:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic finish_test();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    task automatic wr(input logic [7:0] d);
        logic a;
        m.send(d, a);
        chk("ack", a, 1'b1);
        chk("sda_o", sda_o, 1'b0);
    endtask : wr
    task automatic wr_word(input logic [7:0] sub, input word_t w);
        wr(sub);
        wr(w[7:0]);
        wr(w[15:8]);
    endtask : wr_word
    task automatic ptr(input logic [7:0] sub);
        m.start();
        wr(8'hc8);
        wr(sub);
        m.stop();
    endtask : ptr
    task automatic rd(input string name, input word_t exp);
        logic       a;
        logic       r0;
        logic       r1;
        logic [7:0] lo;
        logic [7:0] hi;
        logic [7:0] x;
        m.start();
        m.send(8'hc9, a);
        chk("rd_ack", a, 1'b1);
        m.recv(1'b1, lo, r0);
        m.recv(1'b0, hi, r1);
        m.recv(1'b0, x, r0);
        chk("released", {r1, r0, x}, 10'h3ff);
        chk(name, {hi, lo}, exp);
        m.stop();
    endtask : rd
    // The update pulse lasts one cycle, so polling must start right at the STOP.
    task automatic wait_upd();
        int n = 0;
        while (cmd_update !== 1'b1 && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        chk("cmd_update", cmd_update, 1'b1);
    endtask : wait_upd
    task automatic t_write();
        m.start();
        wr(8'hc8);
        wr_word(SUB_A, 16'h1234);
        wr_word(SUB_B, 16'habcd);
        wr_word(SUB_H, 16'h5a5a);
        chk("cmd_hold", cmd, '0);
        m.stop();
        wait_upd();
        chk("cmd", cmd, {16'h1234, 16'habcd, 16'h5a5a});
        rd("rd_h", 16'h5a5a);
    endtask : t_write
    task automatic t_pending();
        m.start();
        wr(8'hc8);
        wr_word(SUB_A, 16'h1111);
        rd("rd_pend_a", 16'h1111);
        m.start();
        wr(8'hc8);
        wr_word(SUB_B, 16'h2222);
        rd("rd_act_b", 16'habcd);
        rd("rd_new_b", 16'h2222);
    endtask : t_pending
    task automatic t_refuse();
        logic a;
        m.start();
        m.send(8'ha0, a);
        chk("foreign_ack", a, 1'b0);
        m.stop();
        m.start();
        wr(8'hc8);
        wr(SUB_A);
        wr(8'h77);
        m.stop();
        wait_upd();
        chk("cut_pair", cmd.a, 16'h1111);
        m.start();
        wr(8'hc8);
        wr(SUB_H);
        m.glitch();
        wr(8'h3c);
        wr(8'h3c);
        m.stop();
        wait_upd();
        chk("glitch", cmd.h, 16'h3c3c);
    endtask : t_refuse
    task automatic t_status();
        @(negedge clk);
        status.d = 16'h0d0d;
        ptr(SUB_D);
        rd("rd_d", 16'h0d0d);
        @(negedge clk);
        conv_busy = 1'b1;
        status.d = 16'heeee;
        rd("rd_busy", 16'h0d0d);
        conv_busy = 1'b0;
    endtask : t_status
    task automatic t_irq();
        @(negedge clk);
        status.c = 16'h00a5;
        alarm = 1'b1;
        @(negedge clk);
        alarm = 1'b0;
        status.c = 16'h00f0;
        chk("irq_n_low", irq_n, 1'b0);
        ptr(SUB_C);
        rd("rd_c_frozen", 16'h00f5);
        @(negedge clk);
        irq_clear = 1'b1;
        @(negedge clk);
        irq_clear = 1'b0;
        chk("irq_n_high", irq_n, 1'b1);
        rd("rd_c_live", 16'h00f0);
    endtask : t_irq
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            error_cnt++;
            finish_test();
        end
    end
    initial
    begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        #2000;
        t_write();
        t_pending();
        t_refuse();
        t_status();
        t_irq();
        finish_test();
    end
endmodule : i2c_subaddr_register_port_test
